/* rtl/dsk_pkg.sv */
package dsk_pkg;

   // operations this unit executes
   typedef enum logic [1:0] {
      DSK_OP_DEC_MEM = 2'h0, // dec_mem_skip_zero
      DSK_OP_DEC_ACC = 2'h1, // dec_to_acc_skip_zero
      DSK_OP_SBC_MEM = 2'h2  // subtract with borrow into memory
   } dsk_op_t;

   // execution sequence, gray coded
   typedef enum logic [1:0] {
      DSK_ST_IDLE = 2'b00,
      DSK_ST_EXEC = 2'b01,
      DSK_ST_SKIP = 2'b11
   } dsk_state_t;

   localparam int DSK_W = 8;
   localparam logic [DSK_W-1:0] DSK_DEC_STEP = 8'h01;
   localparam logic [DSK_W-1:0] DSK_ZERO = 8'h00;
   localparam int DSK_MSB = DSK_W - 1;
   localparam int DSK_NIB = 4;

   // request from the decoder
   typedef struct packed {
      dsk_op_t op;
      logic [DSK_W-1:0] mem; // addressed data memory byte
      logic [DSK_W-1:0] acc; // accumulator
      logic carry; // carry flag in
   } dsk_req_t;

   // status flags affected by the subtract
   typedef struct packed {
      logic overflow_flag;
      logic zero;
      logic aux_carry_flag;
      logic carry;
      logic signed_compare_flag;
      logic compare_zero_flag;
   } dsk_flags_t;

endpackage

/* rtl/dsk_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module dsk_exec (
   input wire logic clk_sys, // 20 MHz instruction clock
   input wire logic reset, // async, active high
   input wire logic issue, // request valid this cycle
   input wire dsk_pkg::dsk_req_t req, // operation and operands
   output logic ready, // may issue this cycle
   output logic mem_we, // data memory write strobe
   output logic [7:0] mem_wdata, // data memory write value
   output logic acc_we, // accumulator write strobe
   output logic [7:0] acc_wdata, // accumulator write value
   output logic flags_we, // status flag write strobe
   output dsk_pkg::dsk_flags_t flags, // new flag values
   output logic squash // dummy cycle, next instr nullified
);
   import dsk_pkg::*;

   dsk_state_t state;
   dsk_state_t next_state;

   // decrement path, wraps on zero
   wire logic [DSK_W-1:0] dec_val = req.mem - DSK_DEC_STEP;
   wire logic dec_zero = (dec_val == DSK_ZERO);
   wire logic is_dec_mem = issue && (req.op == DSK_OP_DEC_MEM);
   wire logic is_dec_acc = issue && (req.op == DSK_OP_DEC_ACC);
   wire logic is_sbc = issue && (req.op == DSK_OP_SBC_MEM);
   wire logic take_skip = (is_dec_mem || is_dec_acc) && dec_zero;

   // subtract with borrow: acc - mem - !carry
   wire logic borrow_in = !req.carry;
   wire logic [DSK_W:0] sbc_full =
      {1'b0, req.acc} - {1'b0, req.mem} - {{DSK_W{1'b0}}, borrow_in};
   wire logic [DSK_NIB:0] sbc_low =
      {1'b0, req.acc[DSK_NIB-1:0]} - {1'b0, req.mem[DSK_NIB-1:0]}
      - {{DSK_NIB{1'b0}}, borrow_in};
   wire logic [DSK_W-1:0] sbc_res = sbc_full[DSK_W-1:0];
   wire logic sbc_ov = (req.acc[DSK_MSB] ^ req.mem[DSK_MSB])
      & (req.acc[DSK_MSB] ^ sbc_res[DSK_MSB]);
   wire logic sbc_z = (sbc_res == DSK_ZERO);
   dsk_flags_t sbc_flags;

   // flag values of the subtract
   always_comb begin
      sbc_flags.overflow_flag = sbc_ov;
      sbc_flags.zero = sbc_z;
      sbc_flags.aux_carry_flag = !sbc_low[DSK_NIB];
      sbc_flags.carry = !sbc_full[DSK_W]; // cleared on negative
      sbc_flags.signed_compare_flag = sbc_res[DSK_MSB] ^ sbc_ov;
      sbc_flags.compare_zero_flag = sbc_z;
   end

   // sequence: a zero decrement adds the dummy cycle
   always_comb begin
      next_state = DSK_ST_IDLE;
      unique case (state)
         DSK_ST_IDLE, DSK_ST_EXEC: begin
            if (take_skip) begin
               next_state = DSK_ST_SKIP;
            end else if (issue) begin
               next_state = DSK_ST_EXEC;
            end
         end
         DSK_ST_SKIP: begin
            next_state = DSK_ST_IDLE;
         end
         default: begin
            next_state = DSK_ST_IDLE;
         end
      endcase
   end

   // requests are held off during the dummy cycle
   wire logic next_ready = (next_state != DSK_ST_SKIP);

   // state and write strobes
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= DSK_ST_IDLE;
         ready <= 1'b1;
         mem_we <= 1'b0;
         acc_we <= 1'b0;
         flags_we <= 1'b0;
         squash <= 1'b0;
      end else begin
         state <= next_state;
         ready <= next_ready;
         mem_we <= is_dec_mem || is_sbc;
         acc_we <= is_dec_acc;
         flags_we <= is_sbc;
         squash <= take_skip;
      end
   end

   // result data
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mem_wdata <= DSK_ZERO;
         acc_wdata <= DSK_ZERO;
         flags <= '0;
      end else begin
         mem_wdata <= is_sbc ? sbc_res : dec_val;
         acc_wdata <= dec_val;
         flags <= sbc_flags;
      end
   end

   property p_dec_mem;
      @(posedge clk_sys) disable iff (reset)
      is_dec_mem |=> mem_we && !acc_we && !flags_we
         && mem_wdata == $past(req.mem) - DSK_DEC_STEP;
   endproperty
   a_dec_mem: assert property (p_dec_mem)
      else $error("memory decrement result wrong");

   property p_skip_zero;
      @(posedge clk_sys) disable iff (reset)
      (is_dec_mem || is_dec_acc) && req.mem == DSK_DEC_STEP
         |=> squash && !ready ##1 ready && !squash;
   endproperty
   a_skip_zero: assert property (p_skip_zero)
      else $error("zero result did not give one dummy cycle");

   property p_no_skip;
      @(posedge clk_sys) disable iff (reset)
      (is_dec_mem || is_dec_acc) && req.mem != DSK_DEC_STEP
         |=> !squash && ready;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("non-zero result skipped");

   property p_dec_acc;
      @(posedge clk_sys) disable iff (reset)
      is_dec_acc |=> acc_we && !mem_we && !flags_we
         && acc_wdata == $past(req.mem) - DSK_DEC_STEP;
   endproperty
   a_dec_acc: assert property (p_dec_acc)
      else $error("accumulator decrement wrong or memory written");

   property p_acc_skip;
      @(posedge clk_sys) disable iff (reset)
      acc_we |-> squash == (acc_wdata == DSK_ZERO);
   endproperty
   a_acc_skip: assert property (p_acc_skip)
      else $error("skip does not match new accumulator");

   property p_sbc;
      @(posedge clk_sys) disable iff (reset)
      is_sbc |=> mem_we && flags_we && !squash
         && mem_wdata == $past(req.acc) - $past(req.mem)
            - {7'h00, !$past(req.carry)}
         && flags.zero == (mem_wdata == DSK_ZERO);
   endproperty
   a_sbc: assert property (p_sbc)
      else $error("subtract with borrow result wrong");

   property p_wrap;
      @(posedge clk_sys) disable iff (reset)
      is_dec_mem && req.mem == DSK_ZERO
         |=> mem_wdata == 8'hff && !squash;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("decrement of zero did not wrap");

   property p_squash_one;
      @(posedge clk_sys) disable iff (reset)
      squash |-> !ready ##1 !squash;
   endproperty
   a_squash_one: assert property (p_squash_one)
      else $error("dummy cycle longer than one");

   // no strobe ever fires without a taken request
   property p_idle_quiet;
      @(posedge clk_sys) disable iff (reset)
      !(is_dec_mem || is_dec_acc || is_sbc)
         |=> !mem_we && !acc_we && !flags_we && !squash;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("strobe without a request");

   // decrements leave the status flags alone
   property p_dec_no_flags;
      @(posedge clk_sys) disable iff (reset)
      (is_dec_mem || is_dec_acc) |=> !flags_we;
   endproperty
   a_dec_no_flags: assert property (p_dec_no_flags)
      else $error("decrement wrote the flags");

   // carry set when no borrow out of the top bit
   property p_sbc_carry;
      @(posedge clk_sys) disable iff (reset)
      is_sbc |=> flags.carry == ({1'b0, $past(req.acc)}
         >= {1'b0, $past(req.mem)} + {{DSK_W{1'b0}}, !$past(req.carry)});
   endproperty
   a_sbc_carry: assert property (p_sbc_carry)
      else $error("carry flag of subtract wrong");

   // aux carry set when no borrow out of the low nibble
   property p_sbc_aux;
      @(posedge clk_sys) disable iff (reset)
      is_sbc |=> flags.aux_carry_flag
         == ({1'b0, $past(req.acc[DSK_NIB-1:0])}
         >= {1'b0, $past(req.mem[DSK_NIB-1:0])}
            + {{DSK_NIB{1'b0}}, !$past(req.carry)});
   endproperty
   a_sbc_aux: assert property (p_sbc_aux)
      else $error("aux carry flag of subtract wrong");

   // overflow, signed compare and compare zero of the subtract
   property p_sbc_signed;
      @(posedge clk_sys) disable iff (reset)
      is_sbc |=> flags.overflow_flag
         == (($past(req.acc[DSK_MSB]) != $past(req.mem[DSK_MSB]))
            && (mem_wdata[DSK_MSB] != $past(req.acc[DSK_MSB])))
         && flags.signed_compare_flag
            == (mem_wdata[DSK_MSB] != flags.overflow_flag)
         && flags.compare_zero_flag == (mem_wdata == DSK_ZERO);
   endproperty
   a_sbc_signed: assert property (p_sbc_signed)
      else $error("signed flags of subtract wrong");

endmodule
`default_nettype wire

/* verification/dsk_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsk_core_model (
   input wire logic clk_sys, // instruction clock
   input wire logic reset, // async, active high
   input wire logic ld, // preload byte and accumulator
   input wire logic [7:0] ld_m, // preload byte value
   input wire logic [7:0] ld_a, // preload accumulator value
   input wire logic mem_we, // memory write strobe
   input wire logic [7:0] mem_wdata, // memory write value
   input wire logic acc_we, // accumulator write strobe
   input wire logic [7:0] acc_wdata, // accumulator write value
   output logic [7:0] mem_byte, // addressed byte
   output logic [7:0] acc // accumulator
);
   // addressed byte and accumulator take only preloads and strobed writes
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mem_byte <= 8'h00;
         acc <= 8'h00;
      end else if (ld) begin
         mem_byte <= ld_m;
         acc <= ld_a;
      end else begin
         if (mem_we) mem_byte <= mem_wdata;
         if (acc_we) acc <= acc_wdata;
      end
   end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dsk_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic issue = 1'b0;
   logic ld = 1'b0;
   logic carry = 1'b0;
   logic [7:0] ld_m = 8'h00;
   logic [7:0] ld_a = 8'h00;
   dsk_op_t op = DSK_OP_DEC_MEM;
   dsk_req_t req;
   dsk_flags_t flags;
   logic ready, mem_we, acc_we, flags_we, squash;
   logic [7:0] mem_wdata, acc_wdata, mem_byte, acc;
   int fails = 0;
   int checks = 0;
   // operands come from the partner's byte and accumulator
   assign req = '{op: op, mem: mem_byte, acc: acc, carry: carry};
   always #25 clk_sys = ~clk_sys;
   dsk_exec u_dut (.clk_sys(clk_sys), .reset(reset), .issue(issue),
      .req(req), .ready(ready), .mem_we(mem_we), .mem_wdata(mem_wdata),
      .acc_we(acc_we), .acc_wdata(acc_wdata), .flags_we(flags_we),
      .flags(flags), .squash(squash));
   dsk_core_model u_core (.clk_sys(clk_sys), .reset(reset), .ld(ld),
      .ld_m(ld_m), .ld_a(ld_a), .mem_we(mem_we), .mem_wdata(mem_wdata),
      .acc_we(acc_we), .acc_wdata(acc_wdata), .mem_byte(mem_byte),
      .acc(acc));
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // preload, issue one op, judge the answer and the dummy cycle
   task automatic run(dsk_op_t o, logic [7:0] m, logic [7:0] a, logic c);
      logic [8:0] d;
      logic [4:0] h;
      logic [7:0] r;
      logic v, wm, wa, sq;
      logic [7:0] es, ef, ss;
      d = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
      h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
      r = (o == DSK_OP_SBC_MEM) ? d[7:0] : m - 8'h01;
      v = (a[7] ^ m[7]) & (a[7] ^ r[7]);
      wm = (o == DSK_OP_DEC_MEM) || (o == DSK_OP_SBC_MEM);
      wa = (o == DSK_OP_DEC_ACC);
      sq = !o[1] && (r == 8'h00);
      es = {4'h0, wm, wa, o == DSK_OP_SBC_MEM, sq};
      ef = {2'h0, v, r == 8'h00, ~h[4], ~d[8], r[7] ^ v, r == 8'h00};
      @(posedge clk_sys);
      ld <= 1'b1;
      ld_m <= m;
      ld_a <= a;
      carry <= c;
      op <= o;
      @(posedge clk_sys);
      ld <= 1'b0;
      issue <= 1'b1;
      @(posedge clk_sys);
      issue <= 1'b0;
      #1;
      ss = {4'h0, mem_we, acc_we, flags_we, squash};
      chk("strobes", ss, es);
      chk("ready", {7'h00, ready}, {7'h00, !sq});
      if (wm) chk("mem_wdata", mem_wdata, r);
      if (wa) chk("acc_wdata", acc_wdata, r);
      if (o == DSK_OP_SBC_MEM) chk("flags", {2'h0, flags}, ef);
      @(posedge clk_sys);
      #1;
      chk("after", {6'h00, ready, squash}, 8'h02);
      chk("mem_byte", mem_byte, wm ? r : m);
      chk("acc", acc, wa ? r : a);
   endtask
   task automatic t_dec_mem();
      run(DSK_OP_DEC_MEM, 8'h05, 8'h33, 1'b1);
      run(DSK_OP_DEC_MEM, 8'h01, 8'h33, 1'b0);
      run(DSK_OP_DEC_MEM, 8'h00, 8'h33, 1'b1);
   endtask
   task automatic t_dec_acc();
      run(DSK_OP_DEC_ACC, 8'h01, 8'h77, 1'b1);
      run(DSK_OP_DEC_ACC, 8'h80, 8'h00, 1'b0);
      run(DSK_OP_DEC_ACC, 8'h00, 8'h01, 1'b1);
   endtask
   task automatic t_sbc();
      run(DSK_OP_SBC_MEM, 8'h01, 8'h00, 1'b1);
      run(DSK_OP_SBC_MEM, 8'h01, 8'h80, 1'b0);
      run(DSK_OP_SBC_MEM, 8'h10, 8'h11, 1'b0);
      run(DSK_OP_SBC_MEM, 8'h01, 8'h10, 1'b1);
      run(dsk_op_t'(2'h3), 8'h01, 8'h22, 1'b1);
   endtask
   // async reset in the dummy cycle clears strobes at once
   task automatic t_reset_mid();
      @(posedge clk_sys);
      ld <= 1'b1;
      ld_m <= 8'h01;
      op <= DSK_OP_DEC_MEM;
      @(posedge clk_sys);
      ld <= 1'b0;
      issue <= 1'b1;
      @(posedge clk_sys);
      issue <= 1'b0;
      reset <= 1'b1;
      #1;
      chk("reset", {5'h00, ready, mem_we, squash}, 8'h04);
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      run(DSK_OP_DEC_MEM, 8'h05, 8'h33, 1'b1);
   endtask
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      t_dec_mem();
      t_dec_acc();
      t_sbc();
      t_reset_mid();
      report_and_stop();
   end
   // watchdog, far beyond the roughly 60 cycles needed
   initial begin
      #200000;
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
